// ### core/ebw_write_ctrl.sv
// External bus write sequencer with ready wait states, APB registers and timing clock domain
`timescale 1ns/1ps
`default_nettype none
`include "ebw_regs.svh"
module ebw_write_ctrl
	import ebw_pkg::*;
#(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 32
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              interfaceTimingClock,
	input  wire logic              extWaitReady,
	output logic                   busClockOut,
	output logic                   zoneSelectN,
	output logic                   dirReadNotWrite,
	output logic                   writeStrobeLowerN,
	output logic                   writeStrobeUpperN,
	output logic      [ADDR_W-1:0] extAddr,
	output logic      [DATA_W-1:0] extData,
	output logic                   extDataOe
);
	typedef struct packed {
		logic [`EBW_CTRL_W-1:0] ctrl;
		logic [`EBW_TIM_W-1:0]  timing;
		logic [ADDR_W-1:0]      addr;
		logic [DATA_W-1:0]      data;
		logic                   reqTog;
		logic [31:0]            rdata;
	} ebw_core_t;

	typedef struct packed {
		ebw_lstate_t            st;
		logic                   pend;
		logic                   reqSeen;
		logic                   ackTog;
		logic [`EBW_CTRL_W-1:0] cfg;
		logic [3:0]             leadN;
		logic [3:0]             actN;
		logic [3:0]             trailN;
		logic [3:0]             cnt;
		logic [5:0]             since;
		logic                   readyHit;
		logic [7:0]             waitCnt;
		logic [ADDR_W-1:0]      addrLat;
		logic [DATA_W-1:0]      dataLat;
		logic                   zsn;
		logic                   rnw;
		logic                   we0n;
		logic                   we1n;
		logic                   oe;
		logic [ADDR_W-1:0]      aOut;
		logic [DATA_W-1:0]      dOut;
	} ebw_link_t;

	ebw_core_t c;
	ebw_core_t next_c;
	ebw_link_t l;
	ebw_link_t next_l;

	logic linkRstN;
	logic reqSync;
	logic ackSync;
	logic rdy;
	logic divQ;

	ebw_sync2 u_rst_sync (
		.clk  (interfaceTimingClock),
		.rstN (1'b1),
		.din  (rst_n),
		.dout (linkRstN)
	);

	ebw_sync2 u_req_sync (
		.clk  (interfaceTimingClock),
		.rstN (linkRstN),
		.din  (c.reqTog),
		.dout (reqSync)
	);

	ebw_sync2 u_ack_sync (
		.clk  (core_clk),
		.rstN (rst_n),
		.din  (l.ackTog),
		.dout (ackSync)
	);

	ebw_sync2 u_rdy_sync (
		.clk  (interfaceTimingClock),
		.rstN (linkRstN),
		.din  (extWaitReady),
		.dout (rdy)
	);

	ebw_clk_div u_div (
		.clk         (interfaceTimingClock),
		.rstN        (linkRstN),
		.halfRate    (l.cfg[`EBW_CTRL_HALF_CLK]),
		.divQ        (divQ),
		.busClockOut (busClockOut)
	);

	// Core domain: APB slave, zero wait states
	logic busy;
	logic mapped;

	always_comb begin
		next_c = c;
		busy   = c.reqTog != ackSync;
		mapped = (paddr == `EBW_OFF_CTRL) || (paddr == `EBW_OFF_TIMING) ||
			(paddr == `EBW_OFF_ADDR) || (paddr == `EBW_OFF_DATA) ||
			(paddr == `EBW_OFF_CMD) || (paddr == `EBW_OFF_STATUS);
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`EBW_OFF_CTRL:   next_c.rdata = 32'(c.ctrl);
				`EBW_OFF_TIMING: next_c.rdata = 32'(c.timing);
				`EBW_OFF_ADDR:   next_c.rdata = 32'(c.addr);
				`EBW_OFF_DATA:   next_c.rdata = 32'(c.data);
				// Wait count is only stable once the access has been acknowledged
				`EBW_OFF_STATUS: next_c.rdata = {16'h0000, busy ? 8'h00 : l.waitCnt, 7'h00, busy};
				default:         next_c.rdata = 32'h0000_0000;
			endcase
		end
		// Settings stay frozen while an access runs, so the link may latch them unsynchronised
		if (psel && penable && pwrite && !busy) begin
			case (paddr)
				`EBW_OFF_CTRL:   next_c.ctrl = pwdata[`EBW_CTRL_W-1:0];
				`EBW_OFF_TIMING: next_c.timing = pwdata[`EBW_TIM_W-1:0];
				`EBW_OFF_ADDR:   next_c.addr = pwdata[ADDR_W-1:0];
				`EBW_OFF_DATA:   next_c.data = pwdata[DATA_W-1:0];
				`EBW_OFF_CMD:    next_c.reqTog = c.reqTog ^ pwdata[`EBW_CMD_START];
				default:         next_c.reqTog = c.reqTog;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			c        <= '0;
			c.ctrl   <= `EBW_CTRL_RST;
			c.timing <= `EBW_TIM_RST;
		end else begin
			c <= next_c;
		end
	end

	assign prdata  = c.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Link domain: write sequencing on the interface timing clock
	function automatic logic [3:0] scale(input logic [2:0] v, input logic dbl);
		logic [2:0] m;
		m = (v == 3'h0) ? 3'h1 : v;
		return dbl ? {m, 1'b0} : {1'b0, m};
	endfunction

	logic [5:0] total;
	logic       useRdy;
	logic       asyncMode;
	logic       window;
	logic       endAcc;
	logic       active;

	always_comb begin
		next_l    = l;
		endAcc    = 1'b0;
		total     = {2'b00, l.leadN} + {2'b00, l.actN};
		useRdy    = l.cfg[`EBW_CTRL_USE_READY];
		asyncMode = l.cfg[`EBW_CTRL_ASYNC];
		// Async sampling starts two cycles early to pay for the synchroniser on the pin
		window    = asyncMode ? (l.since + 6'h01 + `EBW_ASYNC_ADVANCE >= total)
			: (l.since + 6'h01 == total);
		case (l.st)
			L_IDLE: begin
				if (l.pend) begin
					next_l.pend     = 1'b0;
					next_l.readyHit = 1'b0;
					next_l.waitCnt  = 8'h00;
					next_l.since    = 6'h00;
					next_l.cnt      = l.leadN - 4'h1;
					// Bus clock falls at the next edge, so one dead cycle realigns the start
					if (l.cfg[`EBW_CTRL_HALF_CLK] && divQ) begin
						next_l.st = L_ALIGN;
					end else begin
						next_l.st = L_LEAD;
					end
				end else if (reqSync != l.reqSeen) begin
					next_l.reqSeen = reqSync;
					next_l.pend    = 1'b1;
					next_l.cfg     = c.ctrl;
					next_l.addrLat = c.addr;
					next_l.dataLat = c.data;
					next_l.leadN   = scale({1'b0, c.timing[`EBW_TIM_LEAD_LSB +: 2]},
						c.ctrl[`EBW_CTRL_DOUBLE]);
					next_l.actN    = scale(c.timing[`EBW_TIM_ACT_LSB +: 3], c.ctrl[`EBW_CTRL_DOUBLE]);
					next_l.trailN  = scale({1'b0, c.timing[`EBW_TIM_TRAIL_LSB +: 2]},
						c.ctrl[`EBW_CTRL_DOUBLE]);
				end
			end
			L_ALIGN: begin
				next_l.st = L_LEAD;
			end
			L_LEAD: begin
				next_l.since = l.since + 6'h01;
				if (l.cnt == 4'h0) begin
					next_l.st  = L_ACTIVE;
					next_l.cnt = l.actN - 4'h1;
				end else begin
					next_l.cnt = l.cnt - 4'h1;
				end
			end
			L_ACTIVE: begin
				next_l.since = l.since + 6'h01;
				if (window && rdy) begin
					next_l.readyHit = 1'b1;
				end
				if (l.cnt == 4'h0) begin
					if (!useRdy || l.readyHit || (window && rdy)) begin
						endAcc = 1'b1;
					end else begin
						next_l.st = L_WAIT;
					end
				end else begin
					next_l.cnt = l.cnt - 4'h1;
				end
			end
			L_WAIT: begin
				if (l.waitCnt != 8'hff) begin
					next_l.waitCnt = l.waitCnt + 8'h01;
				end
				if (rdy) begin
					endAcc = 1'b1;
				end
			end
			L_TRAIL: begin
				if (l.cnt == 4'h0) begin
					next_l.st     = L_IDLE;
					next_l.ackTog = ~l.ackTog;
				end else begin
					next_l.cnt = l.cnt - 4'h1;
				end
			end
			default: begin
				next_l.st = L_IDLE;
			end
		endcase
		if (endAcc) begin
			next_l.st  = L_TRAIL;
			next_l.cnt = l.trailN - 4'h1;
		end
		active         = next_l.st inside {L_LEAD, L_ACTIVE, L_WAIT, L_TRAIL};
		next_l.zsn     = !active;
		next_l.rnw     = !active;
		next_l.we0n    = !(next_l.st inside {L_ACTIVE, L_WAIT});
		next_l.oe      = next_l.st inside {L_ACTIVE, L_WAIT, L_TRAIL};
		next_l.dOut    = l.dataLat;
		next_l.aOut    = active ? l.addrLat : {l.aOut[ADDR_W-1:1], 1'b1};
		next_l.we1n    = next_l.cfg[`EBW_CTRL_BUS32] ? next_l.we0n : next_l.aOut[0];
	end

	always_ff @(posedge interfaceTimingClock) begin
		if (!linkRstN) begin
			l      <= '0;
			l.st   <= L_IDLE;
			l.zsn  <= 1'b1;
			l.rnw  <= 1'b1;
			l.we0n <= 1'b1;
			l.we1n <= 1'b1;
			l.aOut <= ADDR_W'(1);
		end else begin
			l <= next_l;
		end
	end

	assign zoneSelectN       = l.zsn;
	assign dirReadNotWrite   = l.rnw;
	assign writeStrobeLowerN = l.we0n;
	assign writeStrobeUpperN = l.we1n;
	assign extAddr           = l.aOut;
	assign extData           = l.dOut;
	assign extDataOe         = l.oe;

	sync_first_sample_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.st == L_ACTIVE && l.cnt == 4'h0 && l.cfg[1:0] == 2'b01 && !rdy) |=> l.st == L_WAIT)
		else $error("sync ready low at first sample did not extend the write");

	wait_resample_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.st == L_WAIT) |=> (l.st == ($past(rdy) ? L_TRAIL : L_WAIT)))
		else $error("wait state did not follow the ready sample");

	async_early_sample_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.st == L_ACTIVE && l.cfg[1:0] == 2'b11 && l.since + 6'h03 == total && rdy)
		|=> (l.readyHit || l.st == L_TRAIL))
		else $error("async ready sample two cycles early was missed");

	async_extend_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.st == L_WAIT && l.cfg[1]) ##0 (!rdy) [*2] |-> l.st == L_WAIT && !l.we0n == 1'b1)
		else $error("async low ready did not keep the write extended");

	idle_addr_hold_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.zsn && $past(l.zsn)) |-> l.aOut[0] && $stable(l.aOut))
		else $error("idle address changed or line zero low");

	lead_aligned_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.st == L_LEAD && $past(l.st) != L_LEAD) |-> (!l.cfg[`EBW_CTRL_HALF_CLK] || divQ))
		else $error("lead phase began off a rising bus clock edge");

	align_inactive_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.st == L_ALIGN) |-> l.zsn && l.rnw && l.we0n && !l.oe ##1 l.st == L_LEAD && !l.zsn)
		else $error("control active during alignment");

	// Split by width so an unknown mode before the first reset edge stays vacuous
	upper_strobe_mode_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		l.cfg[`EBW_CTRL_BUS32] |-> l.we1n == l.we0n)
		else $error("upper strobe does not follow lower strobe in 32-bit mode");

	upper_strobe_addr_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		!l.cfg[`EBW_CTRL_BUS32] |-> l.we1n == l.aOut[0])
		else $error("upper strobe pin does not carry address line zero in 16-bit mode");

	select_dir_pair_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		$fell(l.zsn) |-> $fell(l.rnw) && l.st == L_LEAD && l.we0n)
		else $error("select and direction did not start together in lead");

	no_ready_end_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.st == L_ACTIVE && l.cnt == 4'h0 && !l.cfg[`EBW_CTRL_USE_READY]) |=> l.st != L_WAIT)
		else $error("ready was waited on while disabled");

	trail_hold_a: assert property (@(posedge interfaceTimingClock) disable iff (!linkRstN)
		(l.st == L_TRAIL) |-> l.oe && l.we0n && !l.zsn ##1 (l.st == L_TRAIL || !l.oe))
		else $error("data not held through trail or not released after");
endmodule
`default_nettype wire

// ### core/ebw_regs.svh
// Register offsets, field positions, reset values and timing constants of the write sequencer
`ifndef EBW_REGS_SVH
`define EBW_REGS_SVH
`define EBW_OFF_CTRL        8'h00
`define EBW_OFF_TIMING      8'h04
`define EBW_OFF_ADDR        8'h08
`define EBW_OFF_DATA        8'h0c
`define EBW_OFF_CMD         8'h10
`define EBW_OFF_STATUS      8'h14
`define EBW_CTRL_W          5
`define EBW_CTRL_USE_READY  0
`define EBW_CTRL_ASYNC      1
`define EBW_CTRL_BUS32      2
`define EBW_CTRL_HALF_CLK   3
`define EBW_CTRL_DOUBLE     4
`define EBW_CTRL_RST        5'h04
`define EBW_TIM_W           7
`define EBW_TIM_LEAD_LSB    0
`define EBW_TIM_ACT_LSB     2
`define EBW_TIM_TRAIL_LSB   5
`define EBW_TIM_RST         7'h7f
`define EBW_CMD_START       0
`define EBW_ASYNC_ADVANCE   6'h02
`endif

// ### core/ebw_pkg.sv
// Types shared by the write sequencer modules
package ebw_pkg;
	typedef enum logic [2:0] {L_IDLE, L_ALIGN, L_LEAD, L_ACTIVE, L_WAIT, L_TRAIL} ebw_lstate_t;
	typedef struct packed {
		logic s1;
		logic s2;
	} ebw_sync_t;
endpackage

// ### core/ebw_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ebw_sync2
	import ebw_pkg::*;
(
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic din,
	output logic      dout
);
	ebw_sync_t r;
	ebw_sync_t next_r;

	// First stage feeds only the second stage
	always_comb begin
		next_r.s1 = din;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk) begin
		if (!rstN) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign dout = r.s2;
endmodule
`default_nettype wire

// ### core/ebw_clk_div.sv
// Output bus clock: timing clock itself or timing clock halved
`timescale 1ns/1ps
`default_nettype none
module ebw_clk_div
	import ebw_pkg::*;
(
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic halfRate,
	output logic      divQ,
	output logic      busClockOut
);
	logic q;
	logic next_q;

	// Held high at full rate so every timing edge counts as an aligned start
	always_comb begin
		next_q = halfRate ? ~q : 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rstN) begin
			q <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign divQ        = q;
	assign busClockOut = halfRate ? q : clk;
endmodule
`default_nettype wire

// ### test/ebw_mem_model.sv
// Far-side memory model: stretches writes with ready and watches the bus
`timescale 1ns/1ps
`default_nettype none
module ebw_mem_model (
	input  wire logic        linkClk,
	input  wire logic        armed,
	input  wire logic        bus32,
	input  wire logic [7:0]  holdCnt,
	input  wire logic        busClockOut,
	input  wire logic        selN,
	input  wire logic        dirRnw,
	input  wire logic        weLoN,
	input  wire logic        weHiN,
	input  wire logic [19:0] addr,
	input  wire logic [31:0] data,
	input  wire logic        dataOe,
	output logic             extWaitReady,
	output int               leadCnt,
	output int               strobeCnt,
	output int               trailCnt,
	output int               errCnt,
	output int               accesses,
	output logic      [19:0] gotAddr,
	output logic      [31:0] gotData
);
	logic        inAcc;
	logic [19:0] lastAddr;
	int          cyc;
	initial begin
		extWaitReady = 1'b1;
		inAcc = 0;
		lastAddr = 0;
		errCnt = 0;
		accesses = 0;
		{leadCnt, strobeCnt, trailCnt, cyc} = 0;
	end
	always @(posedge linkClk) begin
		#2;
		if (armed) begin
			if (dirRnw !== selN) errCnt++;
			if (bus32 ? weHiN !== weLoN : weHiN !== addr[0]) errCnt++;
			if (selN === 1'b1) begin
				if (addr !== {lastAddr[19:1], 1'b1}) errCnt++;
				if ({weLoN, weHiN, dataOe} !== 3'b110) errCnt++;
				if (inAcc) accesses++;
				inAcc = 0;
			end else begin
				if (!inAcc) begin
					if (busClockOut !== 1'b1) errCnt++;
					{leadCnt, strobeCnt, trailCnt, cyc} = 0;
					inAcc = 1;
				end
				lastAddr = addr;
				cyc++;
				if (weLoN === 1'b0) begin
					strobeCnt++;
					gotData = data;
					gotAddr = addr;
				end else if (strobeCnt == 0) leadCnt++;
				else begin
					trailCnt++;
					if (dataOe !== 1'b1 || data !== gotData) errCnt++;
				end
			end
		end
		// Ready is pulled high whenever the zone is not selected
		extWaitReady = !(inAcc && cyc < holdCnt);
	end
endmodule
`default_nettype wire

// ### test/ext_bus_write_ready_wait_tb.sv
// Self-checking bench for the external bus write sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ebw_regs.svh"
module ext_bus_write_ready_wait_tb;
	logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic        linkClk, armed, bus32, extWaitReady, busClockOut, selN, dirRnw;
	logic        weLoN, weHiN, dataOe;
	logic [7:0]  paddr, holdCnt;
	logic [31:0] pwdata, prdata, rd, extData, gotData;
	logic [19:0] extAddr, gotAddr;
	int          fails, samples_checked, seed, leadCnt, strobeCnt, trailCnt, errCnt, accesses;

	ebw_write_ctrl u_ebw_write_ctrl (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .interfaceTimingClock(linkClk),
		.extWaitReady(extWaitReady), .busClockOut(busClockOut), .zoneSelectN(selN),
		.dirReadNotWrite(dirRnw), .writeStrobeLowerN(weLoN), .writeStrobeUpperN(weHiN),
		.extAddr(extAddr), .extData(extData), .extDataOe(dataOe));
	ebw_mem_model u_ebw_mem_model (.linkClk(linkClk), .armed(armed), .bus32(bus32),
		.holdCnt(holdCnt), .busClockOut(busClockOut), .selN(selN), .dirRnw(dirRnw),
		.weLoN(weLoN), .weHiN(weHiN), .addr(extAddr), .data(extData), .dataOe(dataOe),
		.extWaitReady(extWaitReady), .leadCnt(leadCnt), .strobeCnt(strobeCnt),
		.trailCnt(trailCnt), .errCnt(errCnt), .accesses(accesses), .gotAddr(gotAddr),
		.gotData(gotData));

	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		linkClk = 0;
		#7;
		forever #32 linkClk = ~linkClk;
	end

	task finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#3000000;
		fails++;
		finish_test();
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	function automatic int eff(input logic [2:0] v, input logic dbl);
		return (v == 0 ? 1 : v) * (dbl ? 2 : 1);
	endfunction

	// Ready reaches the sequencer two link cycles late and the model drops it only once
	// selected, so the first two selected cycles always see it high
	function automatic int exp_wait(input logic [7:0] ctrl, input int ld, input int ac,
		input int hold);
		int first;
		first = ld + ac;
		if (ctrl[`EBW_CTRL_ASYNC])
			first = (ld + ac - 2 > ld + 1) ? ld + ac - 2 : ld + 1;
		if (!ctrl[`EBW_CTRL_USE_READY] || hold == 0 || first < 3 || hold + 2 <= ld + ac)
			return 0;
		return hold + 2 - ld - ac;
	endfunction

	task access(input logic [7:0] ctrl, input logic [6:0] tim, input logic [7:0] hold);
		int a0, eL, eA, w, ew;
		logic [19:0] ad;
		logic [31:0] d;
		ad = 20'($random(seed));
		d = $random(seed);
		holdCnt <= hold;
		bus32 <= ctrl[`EBW_CTRL_BUS32];
		apb(1, `EBW_OFF_ADDR, {12'h0, ad});
		apb(1, `EBW_OFF_DATA, d);
		apb(1, `EBW_OFF_TIMING, {25'h0, tim});
		apb(1, `EBW_OFF_CTRL, {24'h0, ctrl});
		a0 = accesses;
		apb(1, `EBW_OFF_CMD, 32'h1);
		// A write while busy must leave the staged word alone
		apb(1, `EBW_OFF_DATA, ~d);
		apb(0, `EBW_OFF_DATA, 0);
		check("data held", rd, d);
		while (accesses == a0) begin
			@(posedge core_clk);
		end
		do apb(0, `EBW_OFF_STATUS, 0); while (rd[0]);
		eL = eff({1'b0, tim[1:0]}, ctrl[`EBW_CTRL_DOUBLE]);
		eA = eff(tim[4:2], ctrl[`EBW_CTRL_DOUBLE]);
		w = rd[15:8];
		ew = exp_wait(ctrl, eL, eA, hold);
		check("addr out", gotAddr, ad);
		check("data out", gotData, d);
		check("lead", leadCnt, eL);
		check("trail", trailCnt, eff({1'b0, tim[6:5]}, ctrl[`EBW_CTRL_DOUBLE]));
		check("strobe", strobeCnt, eA + ew);
		if (ew == 0)
			check("no wait", w, 0);
		else
			check("waited", w, ew);
	endtask

	initial begin
		seed = 36113;
		{psel, penable, pwrite, paddr, pwdata, holdCnt, armed} = 0;
		{fails, samples_checked} = 0;
		bus32 = 1;
		rst_n = 0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		// Link reset trails by two link flops, so give it time before arming the model
		repeat (4) @(posedge core_clk);
		armed <= 1'b1;
		apb(0, `EBW_OFF_CTRL, 0);
		check("ctrl reset", rd, 32'h4);
		apb(0, `EBW_OFF_TIMING, 0);
		check("timing reset", rd, 32'h7f);
		apb(0, 8'h18, 0);
		check("unmapped err", err, 1'b1);
		check("unmapped data", rd, 32'h0);
		access(8'h04, 7'h25, 8'd20);
		// Lead 1, active 4: long enough that ready can be seen low at the first sample
		access(8'h05, 7'h31, 8'd3);
		access(8'h05, 7'h31, 8'd4);
		access(8'h05, 7'h31, 8'd12);
		access(8'h07, 7'h31, 8'd3);
		access(8'h07, 7'h31, 8'd12);
		access(8'h01, 7'h00, 8'd10);
		access(8'h0d, 7'h7f, 8'd6);
		access(8'h15, 7'h7f, 8'd30);
		repeat (24) access(8'($random(seed)) & 8'h1f, 7'($random(seed)),
			8'($random(seed)) & 8'h1f);
		check("bus watch", errCnt, 0);
		finish_test();
	end
endmodule
`default_nettype wire
